// ### rtl/bit_op_pkg.sv
/*
 Constants for the single-bit instruction unit: instruction fields,
 opcodes and file register geometry.
 Assumes a 12-bit instruction word and a 32-byte file register space.
*/
package bit_op_pkg;
	localparam int INSTR_W = 12;
	localparam int OPC_HI = 11;
	localparam int OPC_LO = 8;
	localparam int BIT_HI = 7;
	localparam int BIT_LO = 5;
	localparam int ADDR_HI = 4;
	localparam int ADDR_LO = 0;
	localparam int ADDR_W = 5;
	localparam int BIDX_W = 3;
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 32;
	localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
	localparam logic [3:0] OPC_BIT_SET = 4'h5;
	localparam logic [3:0] OPC_BIT_TEST = 4'h6;
	localparam logic [7:0] FILE_RESET = 8'h00;
	localparam logic [11:0] NO_OPERATION_WORD = 12'h000;
endpackage

// ### rtl/file_reg_mem.sv
/*
 File register space: 32 bytes, one write port, one read port with
 registered read data.
 Assumes the caller presents the read address one cycle ahead.
*/
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [4:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [bit_op_pkg::REG_COUNT];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < bit_op_pkg::REG_COUNT; i++) begin
				mem[i] <= bit_op_pkg::FILE_RESET;
			end
			rd_data <= bit_op_pkg::FILE_RESET;
		end else begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule // file_reg_mem
`default_nettype wire

// ### rtl/bit_op_instruction_unit.sv
/*
 Decode and execute of the three single-bit instructions.
 Assumes the fetch pipeline presents each instruction word with a
 valid strobe, one cycle ahead of execute; the word after a taken test is dropped here, not by fetch.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_op_instruction_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Fetch side
	input wire logic instr_valid,
	input wire logic [11:0] instr_word,
	// Pipeline control
	output logic flush,
	output logic busy,
	// Debug view of the executed word
	output logic exec_valid,
	output logic [11:0] exec_word,
	output logic [7:0] exec_result
);
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SKIP = 2'b01
	} phase_e;

	typedef enum logic [1:0] {
		OP_OTHER = 2'b00,
		OP_CLEAR = 2'b01,
		OP_SET = 2'b10,
		OP_TEST = 2'b11
	} bit_op_e;

	typedef struct packed {
		phase_e phase;
		logic [11:0] word;
		logic valid;
		logic flush;
		logic busy;
		logic exec_valid;
		logic [11:0] exec_word;
		logic [7:0] exec_result;
		logic fwd_en;
		logic [4:0] fwd_addr;
		logic [7:0] fwd_data;
	} state_s;

	// Quiet state after reset: run phase, nothing pending, outputs low
	localparam state_s IDLE_ST = '{
		phase: ST_RUN,
		word: bit_op_pkg::NO_OPERATION_WORD,
		valid: 1'b0,
		flush: 1'b0,
		busy: 1'b0,
		exec_valid: 1'b0,
		exec_word: bit_op_pkg::NO_OPERATION_WORD,
		exec_result: bit_op_pkg::FILE_RESET,
		fwd_en: 1'b0,
		fwd_addr: 5'h00,
		fwd_data: bit_op_pkg::FILE_RESET
	};

	state_s st;
	state_s next_st;

	logic wr_en;
	logic [4:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] mask;
	logic [3:0] opc;
	logic [2:0] bidx;
	logic [4:0] faddr;
	logic [4:0] rd_addr;
	logic [7:0] cur_byte;
	logic [7:0] set_byte;
	logic [7:0] clear_byte;
	logic bit_zero;
	bit_op_e op;

	// Maps the opcode field onto the bit instruction it names
	function automatic bit_op_e decode_op(input logic [3:0] code);
		unique case (code)
			bit_op_pkg::OPC_BIT_CLEAR: decode_op = OP_CLEAR;
			bit_op_pkg::OPC_BIT_SET: decode_op = OP_SET;
			bit_op_pkg::OPC_BIT_TEST: decode_op = OP_TEST;
			default: decode_op = OP_OTHER;
		endcase
	endfunction

	// Read address comes from the incoming word so data is ready in execute
	assign rd_addr = instr_word[bit_op_pkg::ADDR_HI:bit_op_pkg::ADDR_LO];

	file_reg_mem u_mem (
		.clk(clk),
		.arst_n(arst_n),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	assign opc = st.word[bit_op_pkg::OPC_HI:bit_op_pkg::OPC_LO];
	assign bidx = st.word[bit_op_pkg::BIT_HI:bit_op_pkg::BIT_LO];
	assign faddr = st.word[bit_op_pkg::ADDR_HI:bit_op_pkg::ADDR_LO];
	assign op = decode_op(opc);

	// One mask bit per position of the byte
	for (genvar i = 0; i < bit_op_pkg::DATA_W; i++) begin : g_mask
		assign mask[i] = (bidx == 3'(i));
	end

	// The previous word's write lands as this byte is read: forward it
	assign cur_byte = (st.fwd_en && st.fwd_addr == faddr) ?
		st.fwd_data : rd_data;
	assign set_byte = cur_byte | mask;
	assign clear_byte = cur_byte & ~mask;
	assign bit_zero = (cur_byte & mask) == 8'h00;

	always_comb begin
		next_st = st;
		wr_en = 1'b0;
		wr_addr = faddr;
		wr_data = cur_byte;
		next_st.flush = 1'b0;
		next_st.busy = 1'b0;
		next_st.exec_valid = 1'b0;
		next_st.valid = instr_valid;
		next_st.word = instr_word;
		unique case (st.phase)
			ST_RUN: begin
				// Execute the word taken at the last edge
				if (st.valid) begin
					next_st.exec_valid = 1'b1;
					next_st.exec_word = st.word;
					next_st.exec_result = cur_byte;
					unique case (op)
						OP_CLEAR: begin
							wr_en = 1'b1;
							wr_data = clear_byte;
							next_st.exec_result = clear_byte;
						end
						OP_SET: begin
							wr_en = 1'b1;
							wr_data = set_byte;
							next_st.exec_result = set_byte;
						end
						OP_TEST: begin
							if (bit_zero) begin
								next_st.phase = ST_SKIP;
								next_st.flush = 1'b1;
								next_st.busy = 1'b1;
								next_st.valid = 1'b0;
							end else begin
								next_st.phase = ST_RUN;
							end
						end
						OP_OTHER: begin
							next_st.exec_result = cur_byte;
						end
					endcase
				end
			end
			ST_SKIP: begin
				// Second cycle of a taken test runs a no-operation
				wr_en = 1'b0;
				next_st.exec_valid = 1'b1;
				next_st.exec_word = bit_op_pkg::NO_OPERATION_WORD;
				next_st.exec_result = 8'h00;
				next_st.phase = ST_RUN;
			end
			default: begin
				next_st.phase = ST_RUN;
			end
		endcase
		// Remember this cycle's write for the next word
		next_st.fwd_en = wr_en;
		next_st.fwd_addr = wr_addr;
		next_st.fwd_data = wr_data;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= IDLE_ST;
		end else begin
			st <= next_st;
		end
	end

	assign flush = st.flush;
	assign busy = st.busy;
	assign exec_valid = st.exec_valid;
	assign exec_word = st.exec_word;
	assign exec_result = st.exec_result;
endmodule // bit_op_instruction_unit
`default_nettype wire

// ### bench/bit_op_monitor.sv
/* Checker for the bit instruction unit.
 Sees only the unit's ports; bound after the module. */
`timescale 1ns/1ps
`default_nettype none
module bit_op_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Unit ports
	input wire logic instr_valid,
	input wire logic [11:0] instr_word,
	input wire logic flush,
	input wire logic busy,
	input wire logic exec_valid,
	input wire logic [11:0] exec_word,
	input wire logic [7:0] exec_result
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire logic [3:0] op = exec_word[11:8];
	wire logic hit = exec_result[exec_word[7:5]];
	wire logic ex_t = exec_valid && op == bit_op_pkg::OPC_BIT_TEST;
	sequence s_skip; flush && busy; endsequence
	sequence s_noop; exec_valid && exec_word == 12'h000; endsequence
	chk_flush_noop: assert property (flush |-> s_skip ##1 s_noop)
		else $error("flush without no-op");
	chk_skip_zero: assert property (ex_t && !hit |-> s_skip)
		else $error("missing skip");
	chk_no_skip: assert property (ex_t && hit |-> !flush)
		else $error("wrong skip");
	chk_clear_bit: assert property (exec_valid &&
		op == bit_op_pkg::OPC_BIT_CLEAR |-> !hit) else $error("bit not clear");
	chk_set_bit: assert property (exec_valid &&
		op == bit_op_pkg::OPC_BIT_SET |-> hit) else $error("bit not set");
	chk_word_pipe: assert property ($past(instr_valid, 2) &&
		!$past(flush) |-> exec_valid && exec_word == $past(instr_word, 2))
		else $error("executed word lost");
endmodule // bit_op_monitor
bind bit_op_instruction_unit bit_op_monitor bit_op_monitor_inst (.clk,
	.arst_n, .instr_valid, .instr_word, .flush, .busy, .exec_valid,
	.exec_word, .exec_result);
`default_nettype wire

// ### bench/fetch_model.sv
/* Fetch pipeline model: issues queued words, one per cycle.
 Idle word toggles so stale values never match. */
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
	input wire logic clk,
	output logic instr_valid,
	output logic [11:0] instr_word
);
	logic [11:0] q[$];
	initial begin
		instr_valid = 1'b0;
		instr_word = 12'h000;
	end
	always @(posedge clk) begin
		instr_valid <= q.size() > 0;
		instr_word <= (q.size() > 0) ? q.pop_front() : ~instr_word;
	end
endmodule // fetch_model
`default_nettype wire

// ### bench/tb_top.sv
/* Bench for the bit instruction unit.
 Fetch model feeds words; executed words are logged. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0;
	logic arst_n = 0;
	wire logic instr_valid, flush, busy, exec_valid;
	wire logic [11:0] instr_word, exec_word;
	wire logic [7:0] exec_result;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int nfl = 0;
	int nbusy = 0;
	logic [11:0] wq[$];
	logic [7:0] rq[$];
	always #2.5 clk = ~clk;
	fetch_model fetch_model_inst (.clk, .instr_valid, .instr_word);
	bit_op_instruction_unit bit_op_instruction_unit_inst (.clk, .arst_n,
		.instr_valid, .instr_word, .flush, .busy, .exec_valid,
		.exec_word, .exec_result);
	task conclude;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [11:0] s, input logic [11:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task pop(input logic [11:0] w, input logic [7:0] r);
		chk(wq.pop_front(), w);
		chk({4'h0, rq.pop_front()}, {4'h0, r});
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (exec_valid === 1'b1) begin
			wq.push_back(exec_word);
			rq.push_back(exec_result);
		end
		if (flush === 1'b1) nfl++;
		if (busy === 1'b1) nbusy++;
		if (cyc == 500) begin
			n_mismatch++;
			conclude();
		end
	end
	task t_set_clear;
		@(negedge clk);
		fetch_model_inst.q = '{12'h5FF, 12'h000, 12'h51F, 12'h000, 12'h4FF};
		repeat (9) @(posedge clk);
		pop(12'h5FF, 8'h80);
		pop(12'h000, 8'h00);
		pop(12'h51F, 8'h81);
		pop(12'h000, 8'h00);
		pop(12'h4FF, 8'h01);
		chk(12'(wq.size()), 12'h000);
	endtask
	task t_raw;
		@(negedge clk);
		fetch_model_inst.q = '{12'h41F, 12'h53F};
		repeat (6) @(posedge clk);
		pop(12'h41F, 8'h00);
		pop(12'h53F, 8'h02);
		chk(12'(wq.size()), 12'h000);
	endtask
	task t_skip;
		@(negedge clk);
		fetch_model_inst.q = '{12'h61F, 12'h7E0, 12'h63F, 12'h5E0, 12'h000,
			12'h6E0, 12'h5E0};
		repeat (11) @(posedge clk);
		pop(12'h61F, 8'h01);
		pop(12'h7E0, 8'h00);
		pop(12'h63F, 8'h01);
		pop(12'h000, 8'h00);
		pop(12'h000, 8'h00);
		pop(12'h6E0, 8'h00);
		pop(12'h000, 8'h00);
		chk(12'(nfl), 12'h002);
		chk(12'(nbusy), 12'h002);
		chk(12'(wq.size()), 12'h000);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_set_clear();
		t_skip();
		t_raw();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
